/* File: core/suspend_pad_state_control.sv */
/*
  Pad-state control for the multiplexed power, battery-low, card-detect,
  parallel-port, socket B and GPIO pins. Builds a request per pin from the
  function selects and instantiates one registered decoder per pin.
  Assumes the Suspend and power-off inputs come from the power manager on
  CLK_I; pad inputs arrive from pins and are synchronised here.
*/
// Summary of operation
// - Chip-select I/O inputs stay inputs through Suspend for wake-up sampling.
// - Chip-select I/O outputs keep driving through Suspend, value still programmable.
// - A disabled input pull stays disabled in every mode, Suspend included.
// - Chip-select I/O outputs always have both pulls forced off.
// - Battery-low function drives its pin in all modes with no pulls.
// - Card functions selectable per socket; power-control signals are always outputs.
// - Socket A second card detect pulls up at reset; software may disable it.
// - That input pulls down in Suspend when socket A powers off.
// - Otherwise it keeps its programmable pull-up through Suspend.
// - Shared bank B pins reset as GPIO with pull-ups on.
// - Socket B control pins follow socket A pull and Suspend handling.
// - Parallel pins pull up normally, except EPP outputs drive without pulls.
// - Parallel pins keep pull-ups in Suspend, pull-downs when port powers off, except EPP outputs.
// - EPP outputs hold their last pre-Suspend value throughout Suspend.
// - Socket B outputs have no pulls; inputs have software-disableable pull-ups.
// - In Suspend socket B outputs drive inactive, no pulls, unless powered off.
// - Powered-off socket B outputs float with pull-downs during Suspend.
// - Socket B inputs keep pull-up in Suspend, pull-downs when powered off.
// - GPIO pins do not change state on entering Suspend.
`timescale 1ns/1ps
module suspend_pad_state_control
  import pad_state_pkg::*;
(
  // Clock and reset
  input  wire logic                CLK_I,
  input  wire logic                NRST_I,
  // Power management
  input  wire logic                SUSPEND_I,
  input  wire logic                SOCK_A_PWR_OFF_I,
  input  wire logic                SOCK_B_PWR_OFF_I,
  input  wire logic                PAR_PWR_OFF_I,
  input  wire logic                EPP_MODE_I,
  // Function selects
  input  wire logic                SEL_BATT_LOW_I,
  input  wire logic                SEL_SOCK_A_I,
  input  wire logic                SEL_SOCK_B_I,
  input  wire logic [1:0]          BANK_B_SEL_I,
  // GPIO configuration and data
  input  wire logic [NUM_PINS-1:0] GPIO_DIR_OUT_I,
  input  wire logic [NUM_PINS-1:0] GPIO_PULL_EN_I,
  input  wire logic [NUM_PINS-1:0] GPIO_DOUT_I,
  // Alternate-function data and pulls
  input  wire logic                CARD_DET2_PULL_EN_I,
  input  wire logic                SOCK_B_IN_PULL_EN_I,
  input  wire logic                BATT_LOW_I,
  input  wire logic [2:0]          SOCK_A_PWR_DOUT_I,
  input  wire logic [2:0]          SOCK_B_PWR_DOUT_I,
  input  wire logic [NUM_B-1:0]    PAR_DOUT_I,
  input  wire logic [NUM_B-1:0]    SOCK_B_DOUT_I,
  // Pads
  input  wire logic [NUM_PINS-1:0] PAD_DIN_I,
  output logic      [NUM_PINS-1:0] PAD_OE_O,
  output logic      [NUM_PINS-1:0] PAD_DOUT_O,
  output logic      [NUM_PINS-1:0] PAD_PU_O,
  output logic      [NUM_PINS-1:0] PAD_PD_O,
  // Synchronised pin levels
  output logic      [NUM_PINS-1:0] PIN_DATA_O
);

  pad_req_t                req_w [NUM_PINS];
  pad_ctl_t                ctl_w [NUM_PINS];
  logic     [NUM_PINS-1:0] din_meta_ff;
  logic     [NUM_PINS-1:0] din_sync_ff;

  // Unknown bank B codes fall back to GPIO, the reset-time function
  wire bank_par  = (BANK_B_SEL_I == BANK_PAR);
  wire bank_sock = (BANK_B_SEL_I == BANK_SOCK);

  // Bank A: fixed-function outputs, the card-detect input or GPIO, chosen per socket or by the battery-low select
  genvar a;
  generate
    for (a = 0; a < NUM_A; a++) begin : g_bank_a
      wire       sel_fixed;
      pin_func_t alt_func;
      wire       alt_dout;

      if (a == PIN_BATT_LOW) begin : g_batt
        assign sel_fixed = SEL_BATT_LOW_I;
        assign alt_func  = PF_FIXED;
        assign alt_dout  = BATT_LOW_I;
      end else if (a == PIN_CARD_DET2) begin : g_cdet
        assign sel_fixed = SEL_SOCK_A_I;
        assign alt_func  = PF_CDET;
        assign alt_dout  = 1'b0;
      end else if (a <= PIN_A_VPP2) begin : g_pwr_a
        assign sel_fixed = SEL_SOCK_A_I;
        assign alt_func  = PF_FIXED;
        assign alt_dout  = SOCK_A_PWR_DOUT_I[a-PIN_A_SUPPLY];
      end else begin : g_pwr_b
        assign sel_fixed = SEL_SOCK_B_I;
        assign alt_func  = PF_FIXED;
        assign alt_dout  = SOCK_B_PWR_DOUT_I[a-PIN_B_SUPPLY];
      end

      wire       is_cdet  = (a == PIN_CARD_DET2) && sel_fixed;
      pin_func_t pin_func;
      assign pin_func = sel_fixed ? alt_func : PF_GPIO;

      assign req_w[a] = '{
        func:      pin_func,
        drive:     sel_fixed ? 1'b1 : GPIO_DIR_OUT_I[a],
        pull_en:   is_cdet ? CARD_DET2_PULL_EN_I : GPIO_PULL_EN_I[a],
        pull_down: GPIO_A_PULL_DOWN[a],
        pwr_off:   SOCK_A_PWR_OFF_I,
        epp:       1'b0,
        idle_lvl:  1'b0,
        dout:      sel_fixed ? alt_dout : GPIO_DOUT_I[a]
      };
    end
  endgenerate

  // Bank B: parallel port, socket B control or GPIO for the whole bank
  genvar b;
  generate
    for (b = 0; b < NUM_B; b++) begin : g_bank_b
      localparam int P = NUM_A + b;
      pin_func_t pin_func;
      wire       pin_drive;
      wire       pin_pull;
      wire       pin_off;
      wire       pin_dout;

      assign pin_func  = bank_par ? PF_PAR : (bank_sock ? PF_SOCK : PF_GPIO);
      assign pin_drive = (bank_par | bank_sock) ? BANK_B_OUT_MASK[b] : GPIO_DIR_OUT_I[P];
      // Socket inputs share one software pull enable
      assign pin_pull  = bank_sock ? SOCK_B_IN_PULL_EN_I : GPIO_PULL_EN_I[P];
      assign pin_off   = bank_par ? PAR_PWR_OFF_I : SOCK_B_PWR_OFF_I;
      assign pin_dout  = bank_par ? PAR_DOUT_I[b] : (bank_sock ? SOCK_B_DOUT_I[b] : GPIO_DOUT_I[P]);

      assign req_w[P] = '{
        func:      pin_func,
        drive:     pin_drive,
        pull_en:   pin_pull,
        pull_down: 1'b0,
        pwr_off:   pin_off,
        epp:       EPP_MODE_I,
        idle_lvl:  SOCK_B_IDLE_LVL[b],
        dout:      pin_dout
      };
    end
  endgenerate

  // One registered decoder per pad
  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_cell
      pad_state_cell #(
        .RST_PU (RST_PU_MASK[p]),
        .RST_PD (RST_PD_MASK[p])
      ) u_cell (
        .clk_i   (CLK_I),
        .rst_n_i (NRST_I),
        .req_i   (req_w[p]),
        .susp_i  (SUSPEND_I),
        .ctl_o   (ctl_w[p])
      );

      assign PAD_OE_O[p]   = ctl_w[p].oe;
      assign PAD_DOUT_O[p] = ctl_w[p].dout;
      assign PAD_PU_O[p]   = ctl_w[p].pu;
      assign PAD_PD_O[p]   = ctl_w[p].pd;
    end
  endgenerate

  // Pin levels are asynchronous; the meta stage feeds only the sync stage
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      din_meta_ff <= '0;
      din_sync_ff <= '0;
    end else begin
      din_meta_ff <= PAD_DIN_I;
      din_sync_ff <= din_meta_ff;
    end
  end

  assign PIN_DATA_O = din_sync_ff;

endmodule

/* File: core/pad_state_pkg.sv */
/*
  Shared types and constants for the suspend-aware pad-state control:
  pin indices, reset pull masks, pin directions and inactive levels.
  Assumes a single system clock and an active-low asynchronous reset.
*/
package pad_state_pkg;

  // Pin counts: bank A holds the power, battery-low and card-detect pins,
  // bank B the pins shared by parallel port, socket B and GPIO.
  localparam int NUM_A = 8;
  localparam int NUM_B = 11;
  localparam int NUM_PINS = NUM_A + NUM_B;

  // Bank A pin positions
  localparam int PIN_A_SUPPLY  = 0;
  localparam int PIN_A_VPP1    = 1;
  localparam int PIN_A_VPP2    = 2;
  localparam int PIN_B_SUPPLY  = 3;
  localparam int PIN_B_VPP1    = 4;
  localparam int PIN_B_VPP2    = 5;
  localparam int PIN_BATT_LOW  = 6;
  localparam int PIN_CARD_DET2 = 7;

  // Reset pulls per pin, bit 0 is pin 0; bank B sits at bits 18:8
  localparam logic [NUM_PINS-1:0] RST_PU_MASK = 19'h7ffc0;
  localparam logic [NUM_PINS-1:0] RST_PD_MASK = 19'h0003f;
  // Bank A GPIO inputs 5:0 pull down, the rest pull up
  localparam logic [NUM_A-1:0]    GPIO_A_PULL_DOWN = 8'h3f;

  // Bank B directions in parallel-port and socket use (1 = output)
  localparam logic [NUM_B-1:0] BANK_B_OUT_MASK = 11'h783;
  // Socket B inactive output levels; the reset line idles low
  localparam logic [NUM_B-1:0] SOCK_B_IDLE_LVL = 11'h683;

  typedef enum logic [2:0] {
    PF_GPIO  = 3'b000,
    PF_FIXED = 3'b001,
    PF_CDET  = 3'b010,
    PF_PAR   = 3'b011,
    PF_SOCK  = 3'b100
  } pin_func_t;

  typedef enum logic [1:0] {
    BANK_GPIO = 2'b00,
    BANK_PAR  = 2'b01,
    BANK_SOCK = 2'b10
  } bank_func_t;

  typedef struct packed {
    pin_func_t func;
    logic      drive;
    logic      pull_en;
    logic      pull_down;
    logic      pwr_off;
    logic      epp;
    logic      idle_lvl;
    logic      dout;
  } pad_req_t;

  typedef struct packed {
    logic oe;
    logic dout;
    logic pu;
    logic pd;
  } pad_ctl_t;

endpackage

/* File: core/pad_state_cell.sv */
/*
  One pad's state decoder: output enable, data, pull-up and pull-down,
  registered from the pin's function, direction, Suspend and power-off.
  Assumes all request inputs are on the cell's clock.
*/
`timescale 1ns/1ps
module pad_state_cell
  import pad_state_pkg::*;
#(
  parameter logic RST_PU = 1'b1,
  parameter logic RST_PD = 1'b0
) (
  // Clock and reset
  input  wire logic     clk_i,
  input  wire logic     rst_n_i,
  // Request
  input  wire pad_req_t req_i,
  input  wire logic     susp_i,
  // Pad control
  output pad_ctl_t      ctl_o
);

  // Both resistors on at reset would fight, so refuse such a build
  if (RST_PU && RST_PD) begin : g_bad_reset_pulls
    $error("pad_state_cell: pull-up and pull-down cannot both reset on");
  end

  logic     hold_ff;
  pad_ctl_t ctl_ff;
  pad_ctl_t nxt_ctl;

  wire is_out = req_i.drive;
  wire off    = susp_i & req_i.pwr_off;

  // GPIO ignores Suspend; outputs never carry a pull
  wire g_pu = ~is_out & req_i.pull_en & ~req_i.pull_down;
  wire g_pd = ~is_out & req_i.pull_en & req_i.pull_down;

  wire c_pd = off;
  wire c_pu = ~off & req_i.pull_en;

  // EPP outputs freeze on the value latched before Suspend
  wire p_hold = susp_i & req_i.epp & is_out;
  wire p_oe   = is_out & (~susp_i | req_i.epp | ~req_i.pwr_off);
  wire p_pd   = susp_i & req_i.pwr_off & ~p_hold;
  wire p_pu   = ~p_pd & ~(is_out & req_i.epp);

  wire s_oe   = is_out & ~off;
  wire s_dout = susp_i ? req_i.idle_lvl : req_i.dout;
  wire s_pd   = off;
  wire s_pu   = ~is_out & ~off & req_i.pull_en;

  always_comb begin
    nxt_ctl = '0;
    case (req_i.func)
      PF_GPIO: begin
        nxt_ctl = '{oe: is_out, dout: req_i.dout, pu: g_pu, pd: g_pd};
      end
      PF_FIXED: begin
        nxt_ctl = '{oe: 1'b1, dout: req_i.dout, pu: 1'b0, pd: 1'b0};
      end
      PF_CDET: begin
        nxt_ctl = '{oe: 1'b0, dout: 1'b0, pu: c_pu, pd: c_pd};
      end
      PF_PAR: begin
        nxt_ctl = '{oe: p_oe, dout: p_hold ? hold_ff : req_i.dout, pu: p_pu, pd: p_pd};
      end
      PF_SOCK: begin
        nxt_ctl = '{oe: s_oe, dout: s_dout, pu: s_pu, pd: s_pd};
      end
      default: begin
        nxt_ctl = '0;
      end
    endcase
    // Never fight the two resistors against each other
    nxt_ctl.pu = nxt_ctl.pu & ~nxt_ctl.pd;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_ff <= 1'b0;
    end else if (!susp_i) begin
      hold_ff <= req_i.dout;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_ff <= '{oe: 1'b0, dout: 1'b0, pu: RST_PU, pd: RST_PD};
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  assign ctl_o = ctl_ff;

endmodule

/* File: tb/suspend_pad_state_control_properties.sv */
/*
  Concurrent checks on the pad-state control top-level ports.
  Assumes one clock, CLK_I, and reset NRST_I active low; pad controls lag inputs by one edge.
*/
`timescale 1ns/1ps
module suspend_pad_state_control_properties
  import pad_state_pkg::*;
(
  // Clock and reset
  input  wire logic                CLK_I,
  input  wire logic                NRST_I,
  // Power management and selects
  input  wire logic                SUSPEND_I,
  input  wire logic                SOCK_A_PWR_OFF_I,
  input  wire logic                SOCK_B_PWR_OFF_I,
  input  wire logic                EPP_MODE_I,
  input  wire logic                SEL_BATT_LOW_I,
  input  wire logic                SEL_SOCK_A_I,
  input  wire logic [1:0]          BANK_B_SEL_I,
  // Configuration
  input  wire logic [NUM_PINS-1:0] GPIO_DIR_OUT_I,
  input  wire logic [NUM_PINS-1:0] GPIO_PULL_EN_I,
  input  wire logic                CARD_DET2_PULL_EN_I,
  // Pad controls
  input  wire logic [NUM_PINS-1:0] PAD_OE_O,
  input  wire logic [NUM_PINS-1:0] PAD_DOUT_O,
  input  wire logic [NUM_PINS-1:0] PAD_PU_O,
  input  wire logic [NUM_PINS-1:0] PAD_PD_O
);
  wire logic [10:0] gpio_oe_exp = GPIO_DIR_OUT_I[18:8];
  wire logic [10:0] gpio_pu_exp = ~GPIO_DIR_OUT_I[18:8] & GPIO_PULL_EN_I[18:8];
  wire logic        cdet_off    = SEL_SOCK_A_I & SUSPEND_I & SOCK_A_PWR_OFF_I;
  wire logic        sockb_susp  = (BANK_B_SEL_I == BANK_SOCK) & SUSPEND_I;
  wire logic        epp_susp    = (BANK_B_SEL_I == BANK_PAR) & EPP_MODE_I & SUSPEND_I;

  default clocking dc @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  a_pulls_exclusive: assert property ((PAD_PU_O & PAD_PD_O) == '0)
    else $error("pull-up and pull-down on together");
  a_batt_low_drive: assert property (SEL_BATT_LOW_I |=> PAD_OE_O[6] && !PAD_PU_O[6] && !PAD_PD_O[6])
    else $error("battery-low pin not a plain output");
  a_sock_pwr_out: assert property (SEL_SOCK_A_I |=> PAD_OE_O[2:0] == 3'h7 && (PAD_PU_O[2:0] | PAD_PD_O[2:0]) == 3'h0)
    else $error("socket A power pins not plain outputs");
  a_cdet_pull_down: assert property (cdet_off |=> PAD_PD_O[7] && !PAD_PU_O[7] && !PAD_OE_O[7])
    else $error("card detect not pulled down when powered off");
  a_cdet_pull_keep: assert property (SEL_SOCK_A_I && !cdet_off |=> PAD_PU_O[7] == $past(CARD_DET2_PULL_EN_I) && !PAD_PD_O[7])
    else $error("card detect pull-up not as programmed");
  a_gpio_b_decode: assert property (BANK_B_SEL_I[1] == BANK_B_SEL_I[0] |=>
    PAD_OE_O[18:8] == $past(gpio_oe_exp) && PAD_PU_O[18:8] == $past(gpio_pu_exp))
    else $error("bank B GPIO decode wrong");
  a_sockb_off_float: assert property (sockb_susp && SOCK_B_PWR_OFF_I |=> PAD_OE_O[18:8] == '0 && &PAD_PD_O[18:8])
    else $error("powered-off socket B pins not floating with pull-downs");
  a_sockb_idle_drive: assert property (sockb_susp && !SOCK_B_PWR_OFF_I |=> PAD_OE_O[18:8] == BANK_B_OUT_MASK
    && (PAD_DOUT_O[18:8] & BANK_B_OUT_MASK) == (SOCK_B_IDLE_LVL & BANK_B_OUT_MASK))
    else $error("socket B outputs not idle in Suspend");
  a_epp_hold_value: assert property (epp_susp [*2] |=> $stable(PAD_DOUT_O[18:8] & BANK_B_OUT_MASK))
    else $error("EPP output moved during Suspend");

  c_cdet_off: cover property (cdet_off);
  c_sockb_off: cover property (sockb_susp && SOCK_B_PWR_OFF_I);
  c_epp_hold: cover property (epp_susp [*2]);
endmodule

/* File: tb/pad_far_side.sv */
/*
  Board side of the pads: resolves each pin from the block's enables.
  Assumes no external driver; a floating pin toggles every clock.
*/
`timescale 1ns/1ps
module pad_far_side
  import pad_state_pkg::*;
(
  // Clock
  input  wire logic                clk_i,
  // Pad controls
  input  wire logic [NUM_PINS-1:0] oe_i,
  input  wire logic [NUM_PINS-1:0] dout_i,
  input  wire logic [NUM_PINS-1:0] pu_i,
  input  wire logic [NUM_PINS-1:0] pd_i,
  // Pin levels
  output logic      [NUM_PINS-1:0] din_o
);
  logic [NUM_PINS-1:0] last_ff = '0;
  // Floating pins invert, so a lucky settled value cannot pass a check
  assign din_o = (oe_i & dout_i) | (~oe_i & pu_i) | (~oe_i & ~pu_i & ~pd_i & ~last_ff);
  always_ff @(posedge clk_i) begin
    last_ff <= din_o;
  end
endmodule

/* File: tb/suspend_pad_state_control_tb_top.sv */
/*
  Self-checking bench for the pad-state control, with a board-side pin model.
  Assumes the one-edge decode latency and two-flop pin sampling of the block.
*/
`timescale 1ns/1ps
module suspend_pad_state_control_tb_top
  import pad_state_pkg::*;
;
  localparam logic [NUM_PINS-1:0] BM = 19'h7ff00;
  localparam logic [NUM_PINS-1:0] PDT = 19'(GPIO_A_PULL_DOWN);
  logic                CLK_I, NRST_I, SUSPEND_I, SOCK_A_PWR_OFF_I, SOCK_B_PWR_OFF_I, PAR_PWR_OFF_I, EPP_MODE_I;
  logic                SEL_BATT_LOW_I, SEL_SOCK_A_I, SEL_SOCK_B_I, CARD_DET2_PULL_EN_I, SOCK_B_IN_PULL_EN_I, BATT_LOW_I;
  logic [1:0]          BANK_B_SEL_I;
  logic [2:0]          SOCK_A_PWR_DOUT_I, SOCK_B_PWR_DOUT_I;
  logic [NUM_B-1:0]    PAR_DOUT_I, SOCK_B_DOUT_I;
  logic [NUM_PINS-1:0] GPIO_DIR_OUT_I, GPIO_PULL_EN_I, GPIO_DOUT_I, PAD_DIN_I;
  logic [NUM_PINS-1:0] PAD_OE_O, PAD_DOUT_O, PAD_PU_O, PAD_PD_O, PIN_DATA_O;
  int                  bad_count = 0, check_count = 0, cyc = 0;

  suspend_pad_state_control DUT (.*);
  pad_far_side u_far (.clk_i(CLK_I), .oe_i(PAD_OE_O), .dout_i(PAD_DOUT_O), .pu_i(PAD_PU_O), .pd_i(PAD_PD_O),
                      .din_o(PAD_DIN_I));

  initial begin
    CLK_I = 1'h0;
    forever #2.5 CLK_I = ~CLK_I;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run needs about fifty cycles
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic chk(input logic [NUM_PINS-1:0] got, input logic [NUM_PINS-1:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge CLK_I);
    #1;
  endtask

  task automatic t_gpio();
    GPIO_DIR_OUT_I = 19'h2a5a5;
    GPIO_PULL_EN_I = 19'h7ff0f;
    for (int s = 0; s < 2; s++) begin
      SUSPEND_I = s[0];
      GPIO_DOUT_I = s[0] ? 19'h15a5a : 19'h6a5a5;
      tick();
      chk(PAD_OE_O, GPIO_DIR_OUT_I);
      chk(PAD_PU_O, ~GPIO_DIR_OUT_I & GPIO_PULL_EN_I & ~PDT);
      chk(PAD_PD_O, ~GPIO_DIR_OUT_I & GPIO_PULL_EN_I & PDT);
      chk(PAD_DOUT_O & GPIO_DIR_OUT_I, GPIO_DOUT_I & GPIO_DIR_OUT_I);
    end
    repeat (2) tick();
    chk(PIN_DATA_O & (GPIO_DIR_OUT_I | GPIO_PULL_EN_I),
        (GPIO_DIR_OUT_I & GPIO_DOUT_I) | (~GPIO_DIR_OUT_I & GPIO_PULL_EN_I & ~PDT));
    SUSPEND_I = 1'h0;
  endtask

  task automatic t_fixed();
    {GPIO_DIR_OUT_I, GPIO_PULL_EN_I} = {19'h00000, 19'h7ffff};
    {SEL_BATT_LOW_I, SEL_SOCK_A_I, BATT_LOW_I, SOCK_A_PWR_DOUT_I, SOCK_B_PWR_DOUT_I} = 9'h1ea;
    {SOCK_A_PWR_OFF_I, SOCK_B_PWR_OFF_I} = 2'h3;
    for (int i = 0; i < 4; i++) begin
      {SUSPEND_I, SEL_SOCK_B_I} = i[1:0];
      tick();
      chk(PAD_OE_O & 19'h7f, {12'h000, 1'h1, {3{i[0]}}, 3'h7});
      chk((PAD_PU_O | PAD_PD_O) & {12'h000, 1'h1, {3{i[0]}}, 3'h7}, 19'h00000);
      chk(PAD_DOUT_O & 19'h47, {12'h000, 4'h8, SOCK_A_PWR_DOUT_I});
      chk(PAD_DOUT_O & {12'h000, 1'h0, {3{i[0]}}, 3'h0}, {12'h000, 1'h0, SOCK_B_PWR_DOUT_I & {3{i[0]}}, 3'h0});
    end
  endtask

  task automatic t_cdet();
    for (int i = 0; i < 8; i++) begin
      {CARD_DET2_PULL_EN_I, SOCK_A_PWR_OFF_I, SUSPEND_I} = i[2:0];
      tick();
      chk(19'({PAD_OE_O[7], PAD_PU_O[7], PAD_PD_O[7]}), 19'({1'h0, i[2] & ~(i[0] & i[1]), i[0] & i[1]}));
    end
  endtask

  task automatic t_par();
    logic [10:0] pd;
    BANK_B_SEL_I = BANK_PAR;
    for (int i = 0; i < 8; i++) begin
      {PAR_PWR_OFF_I, EPP_MODE_I, SUSPEND_I} = i[2:0];
      tick();
      pd = (i[0] && i[2]) ? ~((i[0] && i[1]) ? BANK_B_OUT_MASK : 11'h000) : 11'h000;
      chk(PAD_PD_O & BM, {pd, 8'h00});
      chk(PAD_PU_O & BM, {~pd & ~(i[1] ? BANK_B_OUT_MASK : 11'h000), 8'h00});
      chk(PAD_OE_O & BM, {((!i[0] || i[1] || !i[2]) ? BANK_B_OUT_MASK : 11'h000), 8'h00});
    end
    {PAR_PWR_OFF_I, EPP_MODE_I, SUSPEND_I, PAR_DOUT_I} = {3'h2, 11'h3c6};
    tick();
    {SUSPEND_I, PAR_DOUT_I} = {1'h1, 11'h239};
    repeat (2) tick();
    chk(PAD_DOUT_O & {BANK_B_OUT_MASK, 8'h00}, {11'h3c6 & BANK_B_OUT_MASK, 8'h00});
    SUSPEND_I = 1'h0;
    tick();
    chk(PAD_DOUT_O & {BANK_B_OUT_MASK, 8'h00}, {11'h239 & BANK_B_OUT_MASK, 8'h00});
    EPP_MODE_I = 1'h0;
  endtask

  task automatic t_sock();
    logic off;
    {BANK_B_SEL_I, SOCK_B_DOUT_I} = {BANK_SOCK, 11'h14c};
    for (int i = 0; i < 8; i++) begin
      {SOCK_B_IN_PULL_EN_I, SOCK_B_PWR_OFF_I, SUSPEND_I} = i[2:0];
      tick();
      off = i[0] & i[1];
      chk(PAD_OE_O & BM, off ? 19'h00000 : {BANK_B_OUT_MASK, 8'h00});
      chk(PAD_PD_O & BM, off ? BM : 19'h00000);
      chk(PAD_PU_O & BM, (off || !i[2]) ? 19'h00000 : {~BANK_B_OUT_MASK, 8'h00});
      chk(PAD_DOUT_O & {BANK_B_OUT_MASK, 8'h00}, {(i[0] ? SOCK_B_IDLE_LVL : SOCK_B_DOUT_I) & BANK_B_OUT_MASK, 8'h00});
    end
  endtask

  initial begin
    {SUSPEND_I, SOCK_A_PWR_OFF_I, SOCK_B_PWR_OFF_I, PAR_PWR_OFF_I, EPP_MODE_I, SEL_BATT_LOW_I, SEL_SOCK_A_I,
     SEL_SOCK_B_I, CARD_DET2_PULL_EN_I, SOCK_B_IN_PULL_EN_I, BATT_LOW_I, BANK_B_SEL_I} = '0;
    {SOCK_A_PWR_DOUT_I, SOCK_B_PWR_DOUT_I, PAR_DOUT_I, SOCK_B_DOUT_I} = '0;
    {GPIO_DIR_OUT_I, GPIO_PULL_EN_I, GPIO_DOUT_I} = '0;
    NRST_I = 1'h0;
    repeat (10) @(posedge CLK_I);
    #1;
    chk(PAD_PU_O, RST_PU_MASK);
    chk(PAD_PD_O, RST_PD_MASK);
    chk(PAD_OE_O, 19'h00000);
    NRST_I = 1'h1;
    tick();
    t_gpio();
    t_fixed();
    t_cdet();
    t_par();
    t_sock();
    final_report();
  end
endmodule

bind suspend_pad_state_control suspend_pad_state_control_properties u_props (.*);
